//--- verilog/scu_fifo_parity_ctrl.sv
// Purpose: Buffer flag, receive FIFO depth and parity error control
// Assumes: Character engine reports receive and transmit results
// Notes: Registers at 0xc (control), 0xd (data), 0xe (status)
`timescale 1ns/100ps
module scu_fifo_parity_ctrl #(
  parameter int CLKS_PER_HALF_ETU = scu_pkg::DEF_CLKS_PER_HALF_ETU
) (
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic [3:0]              busAddr,
  input  wire logic                    busWr,
  input  wire logic                    busRd,
  input  wire logic [7:0]              busWrData,
  output logic      [7:0]              busRdData,
  input  wire logic                    readerIfEnable,
  input  wire logic                    protoT1,
  input  wire logic                    txMode,
  input  wire logic                    lastCharTxMode,
  input  wire scu_pkg::scu_rx_char_t   rxChar,
  input  wire scu_pkg::scu_tx_result_t txResult,
  output logic                         txLaunch,
  output logic      [7:0]              txData,
  output logic                         fifoEmpty,
  output logic                         txEmptyRxFull,
  output logic                         hostIrqN
);
  typedef struct packed {
    logic [2:0]            retryLimit;
    logic [2:0]            depthSel;
    logic                  tbe;
    logic                  pe;
    logic                  ovr;
    logic [3:0]            errCnt;
    logic [1:0]            clrCnt;
    logic [2:0]            wrPtr;
    logic [2:0]            rdPtr;
    logic [3:0]            count;
    logic                  txModeQ;
    logic [7:0]            rdData;
    logic [7:0]            txData;
    scu_pkg::scu_tx_state_t txState;
    logic [5:0]            halfEtu;
    logic [5:0]            gap;
    logic                  launch;
    logic                  irqN;
  } scu_ctrl_state_t;

  scu_ctrl_state_t s;
  scu_ctrl_state_t next_s;

  logic       halfEtuTick;
  logic [7:0] memRdData;
  logic       wrUtr;
  logic       rdUrr;
  logic       rdUsr;
  logic       push;
  logic       setEv;
  logic       rxFullEv;
  logic       errEv;
  logic       goodEv;
  logic [3:0] depthLen;
  logic [3:0] limitLen;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    return a == target;
  endfunction

  scu_etu_tick #(
    .CLKS_PER_HALF_ETU(CLKS_PER_HALF_ETU)
  ) uTick (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .restart    (s.launch),
    .halfEtuTick(halfEtuTick)
  );

  scu_fifo_mem #(
    .WIDTH(8),
    .DEPTH(scu_pkg::FIFO_MAX_DEPTH)
  ) uMem (
    .clk_sys(clk_sys),
    .wrEn   (push),
    .wrAddr (s.wrPtr),
    .wrData (rxChar.data),
    .rdAddr (s.rdPtr),
    .rdData (memRdData)
  );

  always_comb
  begin
    next_s   = s;
    wrUtr    = busWr && hit(busAddr, scu_pkg::ADDR_DATA_BUFFER);
    rdUrr    = busRd && hit(busAddr, scu_pkg::ADDR_DATA_BUFFER);
    rdUsr    = busRd && hit(busAddr, scu_pkg::ADDR_UART_STATUS);
    depthLen = {1'b0, s.depthSel} + 4'h1;
    limitLen = {1'b0, s.retryLimit} + 4'h1;

    if (busWr && hit(busAddr, scu_pkg::ADDR_FIFO_PARITY_CONTROL))
    begin
      next_s.retryLimit = busWrData[scu_pkg::FCR_LIMIT_LSB +: 3];
      next_s.depthSel   = busWrData[scu_pkg::FCR_DEPTH_LSB +: 3];
    end

    // T0 drops bad characters so the card repeats them; T1 keeps them
    push = rxChar.valid && (protoT1 || !rxChar.parityErr)
           && (s.count < depthLen);
    rxFullEv = push && (s.count + 4'h1 == depthLen);
    if (rxChar.valid && (protoT1 || !rxChar.parityErr) && !push)
    begin
      next_s.ovr = 1'b1;
    end
    else if (rdUsr)
    begin
      next_s.ovr = 1'b0;
    end
    if (push)
    begin
      next_s.wrPtr = s.wrPtr + 3'h1;
    end
    if (rdUrr && s.count != 4'h0)
    begin
      next_s.rdPtr = s.rdPtr + 3'h1;
    end
    next_s.count = s.count + {3'h0, push} - {3'h0, rdUrr && s.count != 4'h0};

    if (busRd)
    begin
      next_s.rdData = 8'h00;
      if (rdUsr)
      begin
        next_s.rdData[scu_pkg::USR_TBE_BIT] = s.tbe;
        next_s.rdData[scu_pkg::USR_OVR_BIT] = s.ovr;
        next_s.rdData[scu_pkg::USR_PE_BIT]  = s.pe;
      end
      else if (rdUrr && s.count != 4'h0)
      begin
        next_s.rdData = memRdData;
      end
    end

    // Parity errors: T1 faults at once, T0 counts receive and NAK events
    errEv  = protoT1 ? (rxChar.valid && rxChar.parityErr)
                     : ((rxChar.valid && rxChar.parityErr) || (txResult.charEnd && txResult.nak));
    goodEv = !protoT1 && ((rxChar.valid && !rxChar.parityErr)
                          || (txResult.charEnd && !txResult.nak));
    if (rdUsr)
    begin
      next_s.pe = 1'b0;
    end
    if (protoT1)
    begin
      next_s.errCnt = 4'h0;
      if (errEv)
      begin
        next_s.pe = 1'b1;
      end
    end
    else if (errEv)
    begin
      if (s.errCnt + 4'h1 >= limitLen)
      begin
        next_s.pe     = 1'b1;
        next_s.errCnt = 4'h0;
      end
      else
      begin
        next_s.errCnt = s.errCnt + 4'h1;
      end
    end
    else if (goodEv && !s.pe)
    begin
      next_s.errCnt = 4'h0;
    end

    // Transmit pacing from the previous start bit
    next_s.launch = 1'b0;
    if (halfEtuTick && s.halfEtu != 6'h3f)
    begin
      next_s.halfEtu = s.halfEtu + 6'h01;
    end
    unique case (s.txState)
      scu_pkg::TX_IDLE:
      begin
        if (wrUtr)
        begin
          next_s.txData  = busWrData;
          next_s.gap     = scu_pkg::REWRITE_HALF_ETU;
          next_s.txState = scu_pkg::TX_WAIT;
        end
      end
      scu_pkg::TX_WAIT:
      begin
        if (wrUtr)
        begin
          next_s.txData = busWrData;
        end
        if (s.halfEtu >= s.gap)
        begin
          next_s.launch  = 1'b1;
          next_s.halfEtu = 6'h00;
          next_s.txState = scu_pkg::TX_BUSY;
        end
      end
      scu_pkg::TX_BUSY:
      begin
        if (txResult.charEnd)
        begin
          // Resend only while the NAK count does not exceed the limit
          if (!protoT1 && txResult.nak && s.errCnt + 4'h1 < limitLen)
          begin
            next_s.gap     = scu_pkg::RESEND_HALF_ETU;
            next_s.txState = scu_pkg::TX_WAIT;
          end
          else
          begin
            next_s.txState = scu_pkg::TX_IDLE;
          end
        end
      end
    endcase

    // Buffer flag: any set wins over a pending clear
    setEv = (txResult.charEnd && (txResult.nak || !lastCharTxMode))
            || rxFullEv
            || (txMode && !s.txModeQ);
    next_s.txModeQ = txMode;
    next_s.clrCnt  = (s.clrCnt != 2'h0) ? s.clrCnt - 2'h1 : 2'h0;
    if (wrUtr || rdUrr)
    begin
      next_s.clrCnt = scu_pkg::CLR_LOAD;
    end
    if (setEv)
    begin
      next_s.tbe = 1'b1;
    end
    else if (s.clrCnt == 2'h1 || (!txMode && s.txModeQ))
    begin
      next_s.tbe = 1'b0;
    end

    if (!readerIfEnable)
    begin
      next_s.tbe     = 1'b0;
      next_s.clrCnt  = 2'h0;
      next_s.pe      = 1'b0;
      next_s.ovr     = 1'b0;
      next_s.errCnt  = 4'h0;
      next_s.count   = 4'h0;
      next_s.wrPtr   = 3'h0;
      next_s.rdPtr   = 3'h0;
      next_s.txState = scu_pkg::TX_IDLE;
      next_s.launch  = 1'b0;
    end
    next_s.irqN = !(next_s.pe || next_s.ovr);
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s            <= '0;
      s.retryLimit <= scu_pkg::FCR_LIMIT_RESET;
      s.depthSel   <= scu_pkg::FCR_DEPTH_RESET;
      s.txState    <= scu_pkg::TX_IDLE;
      s.halfEtu    <= 6'h3f;
      s.irqN       <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign busRdData     = s.rdData;
  assign txLaunch      = s.launch;
  assign txData        = s.txData;
  assign fifoEmpty     = s.count == 4'h0;
  assign txEmptyRxFull = s.tbe;
  assign hostIrqN      = s.irqN;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  sequence quietFlag;
    !setEv && readerIfEnable && !(!txMode && s.txModeQ);
  endsequence

  tbeTxSet_a: assert property (readerIfEnable && txResult.charEnd && (txResult.nak || !lastCharTxMode) |=> txEmptyRxFull) else $error("flag not set at tx end");
  tbeFull_a: assert property (readerIfEnable && rxFullEv |=> txEmptyRxFull) else $error("flag not set on full");
  tbeModeRise_a: assert property (readerIfEnable && txMode && !s.txModeQ |=> txEmptyRxFull) else $error("flag not set on mode switch");
  tbeDisable_a: assert property (!readerIfEnable |=> !txEmptyRxFull && !hostIrqN == 1'b0) else $error("disable did not clear");
  tbeClrDelay_a: assert property ((((wrUtr || rdUrr) && s.tbe) and quietFlag) ##1 quietFlag[*2]
                                  |-> ##0 txEmptyRxFull ##1 !txEmptyRxFull)
    else $error("flag clear timing wrong");
  tbeModeFall_a: assert property (readerIfEnable && !txMode && s.txModeQ && !setEv |=> !txEmptyRxFull) else $error("flag kept on rx switch");
  peLimit_a: assert property (readerIfEnable && !protoT1 && errEv && s.errCnt + 4'h1 == limitLen |=> s.pe) else $error("fault not raised at limit");
  irqFollow_a: assert property (s.pe |-> !hostIrqN) else $error("irq high with fault");
  goodReset_a: assert property (readerIfEnable && !protoT1 && !errEv && goodEv && !s.pe |=> s.errCnt == 4'h0) else $error("counter not reset");
  peHold_a: assert property (readerIfEnable && s.pe && !rdUsr |=> s.pe) else $error("fault dropped early");
  resendGap_a: assert property (s.launch |-> $past(s.halfEtu) >= $past(s.gap) && ($past(s.gap) == scu_pkg::RESEND_HALF_ETU || $past(s.gap) == scu_pkg::REWRITE_HALF_ETU)) else $error("launch before gap");
  t1First_a: assert property (readerIfEnable && protoT1 && rxChar.valid && rxChar.parityErr |=> s.pe) else $error("T1 fault missed");
  t1Store_a: assert property (readerIfEnable && protoT1 && rxChar.valid && s.count < depthLen && !rdUrr |=> s.count == $past(s.count) + 4'h1) else $error("T1 char not stored");
  depthBound_a: assert property (s.count <= depthLen) else $error("fifo over depth");
endmodule // scu_fifo_parity_ctrl

//--- verilog/scu_pkg.sv
// Purpose: Constants and types for the card UART flag, FIFO and parity block
// Assumes: One 100 MHz clock, 8-bit controller register port
// Notes: Functional notes below
// Functional notes
// - Flag set at character end, unless clean LAST_CHAR_TX_MODE
// - Flag set when receive buffer fills
// - Flag set on reception to transmission switch
// - Flag cleared at reset or interface disable
// - Flag cleared by transmit buffer write
// - Clear lands three cycles after access
// - Flag cleared by receive buffer read
// - Flag cleared on transmission to reception switch
// - Parity fault at limit plus one errors
// - Parity fault pulls host interrupt low
// - T0 good character resets error counter, except while parity fault is held
// - Parity fault held until status read
// - Limit zero: no resend, rewrite at 13.5 ETU
// - T1: counter idle, first error faults
// - T1 keeps characters with parity errors
// - Depth field 0..7 gives 1..8 characters
package scu_pkg;
  localparam logic [3:0] ADDR_FIFO_PARITY_CONTROL = 4'hc;
  localparam logic [3:0] ADDR_DATA_BUFFER         = 4'hd;
  localparam logic [3:0] ADDR_UART_STATUS         = 4'he;
  localparam int         FCR_LIMIT_LSB            = 4;
  localparam int         FCR_DEPTH_LSB            = 0;
  localparam int         USR_TBE_BIT              = 0;
  localparam int         USR_OVR_BIT              = 2;
  localparam int         USR_PE_BIT               = 3;
  localparam logic [2:0] FCR_LIMIT_RESET          = 3'h0;
  localparam logic [2:0] FCR_DEPTH_RESET          = 3'h0;
  localparam int         TBE_CLEAR_DELAY_CYC      = 3;
  localparam logic [1:0] CLR_LOAD                 = 2'(TBE_CLEAR_DELAY_CYC - 1);
  // Gaps in ETU, then in half ETU, measured from the previous start bit
  localparam real        RESEND_ETU               = 15.0;
  localparam real        REWRITE_ETU              = 13.5;
  localparam logic [5:0] RESEND_HALF_ETU          = 6'(int'(RESEND_ETU * 2.0));
  localparam logic [5:0] REWRITE_HALF_ETU         = 6'(int'(REWRITE_ETU * 2.0));
  localparam int         DEF_CLKS_PER_HALF_ETU    = 186;
  localparam int         FIFO_MAX_DEPTH           = 8;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       parityErr;
  } scu_rx_char_t;

  typedef struct packed {
    logic charEnd;
    logic nak;
  } scu_tx_result_t;

  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_BUSY} scu_tx_state_t;
endpackage

//--- verilog/scu_fifo_mem.sv
// Purpose: Character store for the receive FIFO
// Assumes: Write and read addresses managed by the owner
// Notes: Read data registered, one cycle behind the address
`timescale 1ns/100ps
module scu_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = scu_pkg::FIFO_MAX_DEPTH
) (
  input  wire logic                     clk_sys,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rdData;
  } scu_mem_state_t;

  scu_mem_state_t s;
  scu_mem_state_t next_s;

  if (DEPTH < 2 || WIDTH < 1)
  begin : gChk
    $error("scu_fifo_mem: unsupported size");
  end

  always_comb
  begin
    next_s = s;
    if (wrEn)
    begin
      next_s.mem[wrAddr] = wrData;
    end
    next_s.rdData = s.mem[rdAddr];
  end

  // No reset: contents are don't-care until written
  always_ff @(posedge clk_sys)
  begin
    s <= next_s;
  end

  assign rdData = s.rdData;
endmodule // scu_fifo_mem

//--- verilog/scu_etu_tick.sv
// Purpose: Half-ETU enable pulse from the system clock
// Assumes: ETU is a whole number of system clocks times two
// Notes: restart realigns the phase to a start bit
`timescale 1ns/100ps
module scu_etu_tick #(
  parameter int CLKS_PER_HALF_ETU = scu_pkg::DEF_CLKS_PER_HALF_ETU
) (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic restart,
  output logic      halfEtuTick
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } scu_tick_state_t;

  localparam logic [15:0] LAST = 16'(CLKS_PER_HALF_ETU - 1);

  scu_tick_state_t s;
  scu_tick_state_t next_s;

  if (CLKS_PER_HALF_ETU < 1 || CLKS_PER_HALF_ETU > 65536)
  begin : gChk
    $error("scu_etu_tick: divider out of range");
  end

  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (restart || s.cnt == LAST)
    begin
      next_s.cnt = 16'h0000;
      next_s.tick = !restart;
    end
    else
    begin
      next_s.cnt = s.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign halfEtuTick = s.tick;
endmodule // scu_etu_tick

//--- bench/scu_card_model.sv
// Purpose: Card side model: answers sent characters, supplies received ones
// Assumes: One character lasts CHAR_CYC clocks on the line
// Notes: Released data shows the inverse of the last value
`timescale 1ns/100ps
module scu_card_model #(
  parameter int CHAR_CYC = 40
) (
  input  wire logic               clk_sys,
  input  wire logic               txLaunch,
  input  wire logic               nakCmd,
  output scu_pkg::scu_rx_char_t   rxChar,
  output scu_pkg::scu_tx_result_t txResult,
  output int                      launches,
  output int                      gap
);
  int age = 0;
  int busy = 0;

  initial
  begin
    rxChar = '0;
    txResult = '0;
    launches = 0;
    gap = 0;
  end

  // Gap is counted in clocks between two launches
  always @(posedge clk_sys)
  begin
    age <= age + 1;
    txResult <= '0;
    if (txLaunch)
    begin
      launches <= launches + 1;
      gap <= age + 1;
      age <= 0;
      busy <= CHAR_CYC;
    end
    else if (busy > 0)
    begin
      busy <= busy - 1;
      if (busy == 1)
        txResult <= '{charEnd: 1'b1, nak: nakCmd};
    end
  end

  task automatic sendChar(input logic [7:0] d, input logic pe);
    @(posedge clk_sys);
    rxChar <= '{valid: 1'b1, data: d, parityErr: pe};
    @(posedge clk_sys);
    rxChar <= '{valid: 1'b0, data: ~d, parityErr: ~pe};
  endtask
endmodule // scu_card_model

//--- bench/testbench.sv
// Purpose: Self-checking bench for the buffer flag, FIFO and parity block
// Assumes: Half ETU of 2 clocks, card model answers after 40 clocks
// Notes: Queue model predicts FIFO order and parity fault
`timescale 1ns/100ps
module testbench;
  logic                    clk_sys = 1'b0;
  logic                    sys_rst = 1'b1;
  logic [3:0]              busAddr = 4'h0;
  logic                    busWr = 1'b0;
  logic                    busRd = 1'b0;
  logic [7:0]              busWrData = 8'h00;
  logic [7:0]              busRdData;
  logic                    readerIfEnable = 1'b1;
  logic                    protoT1 = 1'b0;
  logic                    txMode = 1'b0;
  logic                    lastCharTxMode = 1'b0;
  logic                    nakCmd = 1'b0;
  scu_pkg::scu_rx_char_t   rxChar;
  scu_pkg::scu_tx_result_t txResult;
  logic                    txLaunch;
  logic [7:0]              txData;
  logic                    fifoEmpty;
  logic                    txEmptyRxFull;
  logic                    hostIrqN;
  int                      launches;
  int                      gap;
  int                      fails = 0;
  int                      compares = 0;
  int                      pec = 0;
  int                      lim = 0;
  int                      n0;
  bit                      expFault = 0;
  logic [7:0]              lfsr = 8'h3c;
  logic [7:0]              expQ[$];
  logic [7:0]              v;

  always #5 clk_sys = ~clk_sys;

  scu_fifo_parity_ctrl #(.CLKS_PER_HALF_ETU(2)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .busAddr(busAddr), .busWr(busWr),
    .busRd(busRd), .busWrData(busWrData), .busRdData(busRdData),
    .readerIfEnable(readerIfEnable), .protoT1(protoT1), .txMode(txMode),
    .lastCharTxMode(lastCharTxMode), .rxChar(rxChar), .txResult(txResult),
    .txLaunch(txLaunch), .txData(txData), .fifoEmpty(fifoEmpty),
    .txEmptyRxFull(txEmptyRxFull), .hostIrqN(hostIrqN));

  scu_card_model i_card (
    .clk_sys(clk_sys), .txLaunch(txLaunch), .nakCmd(nakCmd), .rxChar(rxChar),
    .txResult(txResult), .launches(launches), .gap(gap));

  function automatic logic [7:0] nextRand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    busAddr <= a;
    busWrData <= d;
    busWr <= 1'b1;
    @(posedge clk_sys);
    busWr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge clk_sys);
    busRd <= 1'b0;
    cyc(1);
    d = busRdData;
  endtask

  // Bench model: T0 drops bad chars, T1 keeps them and faults at once
  task automatic rx(input logic pe);
    lfsr = nextRand(lfsr);
    i_card.sendChar(lfsr, pe);
    if (protoT1)
    begin
      if (pe)
        expFault = 1;
      expQ.push_back(lfsr);
    end
    else if (pe)
    begin
      pec++;
      if (pec == lim + 1)
      begin
        expFault = 1;
        pec = 0;
      end
    end
    else
    begin
      if (!expFault)
        pec = 0;
      expQ.push_back(lfsr);
    end
    cyc(2);
    chk(hostIrqN, !expFault);
  endtask

  task automatic drain;
    while (expQ.size() > 0)
    begin
      rd(scu_pkg::ADDR_DATA_BUFFER, v);
      chk(v, expQ.pop_front());
    end
    chk(fifoEmpty, 1'b1);
  endtask

  task automatic clearFault;
    rd(scu_pkg::ADDR_UART_STATUS, v);
    chk(v & 8'h08, 8'h08);
    expFault = 0;
    cyc(1);
    chk(hostIrqN, 1'b1);
  endtask

  task automatic waitEnd;
    for (int i = 0; i < 200; i++)
    begin
      cyc(1);
      if (txResult.charEnd)
        break;
    end
  endtask

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #200000;
    fails++;
    finish_test();
  end

  initial
  begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    cyc(1);
    chk(txEmptyRxFull, 1'b0);
    chk(hostIrqN, 1'b1);
    chk(fifoEmpty, 1'b1);
    // Depth of three characters
    wr(scu_pkg::ADDR_FIFO_PARITY_CONTROL, 8'h02);
    rx(0);
    rx(0);
    chk(txEmptyRxFull, 1'b0);
    rx(0);
    chk(txEmptyRxFull, 1'b1);
    rd(scu_pkg::ADDR_DATA_BUFFER, v);
    chk(v, expQ.pop_front());
    chk(txEmptyRxFull, 1'b1);
    cyc(1);
    chk(txEmptyRxFull, 1'b0);
    drain();
    repeat (3) rx(0);
    @(posedge clk_sys);
    readerIfEnable <= 1'b0;
    @(posedge clk_sys);
    readerIfEnable <= 1'b1;
    cyc(1);
    chk(txEmptyRxFull, 1'b0);
    chk(fifoEmpty, 1'b1);
    expQ.delete();
    // T0 parity counting, limit 1 means two errors
    lim = 1;
    wr(scu_pkg::ADDR_FIFO_PARITY_CONTROL, 8'h17);
    rx(1);
    rx(0);
    rx(1);
    rx(1);
    cyc(5);
    chk(hostIrqN, 1'b0);
    clearFault();
    drain();
    @(posedge clk_sys);
    protoT1 <= 1'b1;
    rx(0);
    rx(1);
    clearFault();
    drain();
    @(posedge clk_sys);
    protoT1 <= 1'b0;
    txMode <= 1'b1;
    cyc(2);
    chk(txEmptyRxFull, 1'b1);
    // Clean sends with limit 0
    wr(scu_pkg::ADDR_FIFO_PARITY_CONTROL, 8'h00);
    wr(scu_pkg::ADDR_DATA_BUFFER, 8'ha5);
    cyc(1);
    chk(txEmptyRxFull, 1'b1);
    cyc(1);
    chk(txEmptyRxFull, 1'b0);
    waitEnd();
    cyc(1);
    chk(txEmptyRxFull, 1'b1);
    chk(txData, 8'ha5);
    @(posedge clk_sys);
    lastCharTxMode <= 1'b1;
    wr(scu_pkg::ADDR_DATA_BUFFER, 8'h5a);
    waitEnd();
    chk(gap >= 54 && gap <= 58, 1);
    cyc(2);
    chk(txEmptyRxFull, 1'b0);
    // One retry allowed, first attempt rejected
    @(posedge clk_sys);
    lastCharTxMode <= 1'b0;
    wr(scu_pkg::ADDR_FIFO_PARITY_CONTROL, 8'h10);
    n0 = launches;
    nakCmd <= 1'b1;
    wr(scu_pkg::ADDR_DATA_BUFFER, 8'h96);
    waitEnd();
    nakCmd <= 1'b0;
    waitEnd();
    chk(8'(launches - n0), 8'h02);
    chk(gap >= 60 && gap <= 64, 1);
    chk(hostIrqN, 1'b1);
    // Limit 0: rejection faults with no resend
    wr(scu_pkg::ADDR_FIFO_PARITY_CONTROL, 8'h00);
    n0 = launches;
    nakCmd <= 1'b1;
    wr(scu_pkg::ADDR_DATA_BUFFER, 8'h69);
    waitEnd();
    nakCmd <= 1'b0;
    cyc(80);
    chk(8'(launches - n0), 8'h01);
    chk(hostIrqN, 1'b0);
    chk(txEmptyRxFull, 1'b1);
    clearFault();
    @(posedge clk_sys);
    txMode <= 1'b0;
    cyc(2);
    chk(txEmptyRxFull, 1'b0);
    finish_test();
  end
endmodule // testbench
